// >>> cep_defines.vh
// Purpose: constants for the counter input engine
// Assumes: byte addresses on an AXI4-Lite slave, 32-bit data
// Notes: definitions only
`ifndef CEP_DEFINES_VH
`define CEP_DEFINES_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CEP_OFS_CTRL      8'h00
`define CEP_OFS_CFG       8'h04
`define CEP_OFS_INIT      8'h08
`define CEP_OFS_COUNT     8'h0C
`define CEP_OFS_STATUS    8'h10
`define CEP_OFS_FIFO      8'h14
`define CEP_OFS_LEVEL     8'h18
// ----------------------------------------
// ctrl fields (write only one-cycle strobes, arm included)
// ----------------------------------------
`define CEP_CTRL_ARM      0
`define CEP_CTRL_DISARM   1
`define CEP_CTRL_CLR_ERR  2
// ----------------------------------------
// cfg fields
// ----------------------------------------
`define CEP_CFG_MODE_LO   0
`define CEP_CFG_MODE_HI   2
`define CEP_CFG_SRC_FALL  3
`define CEP_CFG_PAUSE_EN  4
`define CEP_CFG_PAUSE_HI  5
`define CEP_CFG_DIR_LO    6
`define CEP_CFG_DIR_HI    7
`define CEP_CFG_SMP_FALL  8
`define CEP_CFG_PW_LOW    9
`define CEP_CFG_SEL_LO    16
`define CEP_CFG_SEL_HI    21
`define CEP_CFG_RESET     32'h0000_0000
// ----------------------------------------
// modes
// ----------------------------------------
`define CEP_MODE_EDGE_OD  3'h0
`define CEP_MODE_EDGE_BUF 3'h1
`define CEP_MODE_PW_ONE   3'h2
`define CEP_MODE_PW_IMP   3'h3
`define CEP_MODE_PW_SMP   3'h4
`define CEP_MODE_PW_HW_TIMED_SINGLE_POINT 3'h5
// ----------------------------------------
// direction
// ----------------------------------------
`define CEP_DIR_UP        2'h0
`define CEP_DIR_DOWN      2'h1
`define CEP_DIR_AUX       2'h2
// ----------------------------------------
// status bits
// ----------------------------------------
`define CEP_ST_ARMED      0
`define CEP_ST_OVERRUN    1
`define CEP_ST_FIFO_ERR   2
`define CEP_ST_DONE       3
`define CEP_ST_EMPTY      4
`define CEP_ST_FULL       5
// ----------------------------------------
// sample clock selector: 0..1 ao/di clocks, 2 di start, 3 do clock,
// 4..7 counter outputs, 8..23 function lines, 24..31 pxi trig,
// 32..39 sync bus, 40..41 star lines, 42 change detect
// ----------------------------------------
`define CEP_SEL_COUNT     43
`define CEP_AXI_OKAY      2'h0
`define CEP_AXI_SLVERR    2'h2
`endif

// >>> cep_counter.v
// Purpose: counter input engine: edge counting and pulse width, with fifo
// Assumes: source, gate, aux and sample lines are asynchronous to aclk
// Notes: sample clock comes from a routed line, or is held low for a selector of 43 and up; never a divider
`timescale 1ns/1ns
`include "cep_defines.vh"

module cep_counter #(
	parameter CW          = 32,
	parameter FIFO_DEPTH  = 16,
	parameter FIFO_AW     = 4,
	parameter SEL_N       = `CEP_SEL_COUNT
) (
	// clock and reset
	input  wire              aclk,
	input  wire              aresetn,
	// axi4-lite write
	input  wire [7:0]        s_axi_awaddr,
	input  wire              s_axi_awvalid,
	output reg               s_axi_awready,
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	input  wire              s_axi_wvalid,
	output reg               s_axi_wready,
	output reg  [1:0]        s_axi_bresp,
	output reg               s_axi_bvalid,
	input  wire              s_axi_bready,
	// axi4-lite read
	input  wire [7:0]        s_axi_araddr,
	input  wire              s_axi_arvalid,
	output reg               s_axi_arready,
	output reg  [31:0]       s_axi_rdata,
	output reg  [1:0]        s_axi_rresp,
	output reg               s_axi_rvalid,
	input  wire              s_axi_rready,
	// counter inputs
	input  wire              ctr_source,
	input  wire              ctr_gate,
	input  wire              ctr_aux_dir,
	input  wire [SEL_N-1:0]  sample_lines,
	// dma drain side
	output reg  [CW-1:0]     dma_data,
	output reg               dma_valid,
	input  wire              dma_ready,
	// status
	output reg               armed_out,
	output reg               error_out
);

// ----------------------------------------
// input synchronisers
// ----------------------------------------
reg [2:0]  meta_reg;
reg [2:0]  sync_reg;
reg [2:0]  prev_reg;
reg [SEL_N-1:0] lines_meta_reg;
reg [SEL_N-1:0] lines_sync_reg;
reg        smp_sync_reg;
reg        smp_prev_reg;
reg [5:0]  sel_reg;
wire       smp_mux;

// every line is synchronised before the mux, so no logic reads a raw pin
assign smp_mux = ({26'h0, sel_reg} < SEL_N) ? lines_sync_reg[sel_reg] : 1'b0;

always @(posedge aclk) begin
	if (!aresetn) begin
		meta_reg     <= 3'h0;
		sync_reg     <= 3'h0;
		prev_reg     <= 3'h0;
		lines_meta_reg <= {SEL_N{1'b0}};
		lines_sync_reg <= {SEL_N{1'b0}};
		smp_sync_reg <= 1'b0;
		smp_prev_reg <= 1'b0;
	end else begin
		meta_reg     <= {ctr_aux_dir, ctr_gate, ctr_source};
		sync_reg     <= meta_reg;
		prev_reg     <= sync_reg;
		lines_meta_reg <= sample_lines;
		lines_sync_reg <= lines_meta_reg;
		smp_sync_reg <= smp_mux;
		smp_prev_reg <= smp_sync_reg;
	end
end

// ----------------------------------------
// configuration and edge decode
// ----------------------------------------
reg  [31:0]   cfg_reg;
reg  [CW-1:0] init_reg;
wire [2:0]    mode = cfg_reg[`CEP_CFG_MODE_HI:`CEP_CFG_MODE_LO];
wire [1:0]    dir  = cfg_reg[`CEP_CFG_DIR_HI:`CEP_CFG_DIR_LO];
wire src_rise = sync_reg[0] & ~prev_reg[0];
wire src_fall = ~sync_reg[0] & prev_reg[0];
wire src_edge = cfg_reg[`CEP_CFG_SRC_FALL] ? src_fall : src_rise;
wire gate_act = sync_reg[1] ^ cfg_reg[`CEP_CFG_PW_LOW];
wire gate_was = prev_reg[1] ^ cfg_reg[`CEP_CFG_PW_LOW];
wire gate_lead  = gate_act & ~gate_was;
wire gate_trail = ~gate_act & gate_was;
wire paused = cfg_reg[`CEP_CFG_PAUSE_EN]
	& (sync_reg[1] == cfg_reg[`CEP_CFG_PAUSE_HI]);
wire smp_edge = cfg_reg[`CEP_CFG_SMP_FALL]
	? (~smp_sync_reg & smp_prev_reg)
	: (smp_sync_reg & ~smp_prev_reg);
wire count_down = (dir == `CEP_DIR_DOWN)
	| ((dir == `CEP_DIR_AUX) & ~sync_reg[2]);
wire is_edge  = (mode == `CEP_MODE_EDGE_OD) | (mode == `CEP_MODE_EDGE_BUF);
wire is_smp_pw = (mode == `CEP_MODE_PW_SMP) | (mode == `CEP_MODE_PW_HW_TIMED_SINGLE_POINT);

// ----------------------------------------
// measurement state machine
// ----------------------------------------
localparam ST_IDLE = 4'b0001;
localparam ST_WAIT = 4'b0010;
localparam ST_MEAS = 4'b0100;
localparam ST_DONE = 4'b1000;

reg  [3:0]    state_reg;
reg  [CW-1:0] count_reg;
reg  [CW-1:0] last_pw_reg;
reg           pw_new_reg;
reg           overrun_reg;
reg           fifo_err_reg;
reg           arm_pulse;
reg           disarm_pulse;
reg           clr_err_pulse;
reg           push;
reg  [CW-1:0] push_data;
wire          fifo_full;

always @* begin
	push      = 1'b0;
	push_data = count_reg;
	if (state_reg == ST_MEAS) begin
		if (mode == `CEP_MODE_EDGE_BUF && smp_edge) begin
			push = 1'b1;
		end else if ((mode == `CEP_MODE_PW_ONE || mode == `CEP_MODE_PW_IMP)
			&& gate_trail) begin
			push = 1'b1;
		end
	end
	if (is_smp_pw && state_reg != ST_IDLE && smp_edge && pw_new_reg) begin
		push      = 1'b1;
		push_data = last_pw_reg;
	end
end

always @(posedge aclk) begin
	if (!aresetn) begin
		state_reg    <= ST_IDLE;
		count_reg    <= {CW{1'b0}};
		last_pw_reg  <= {CW{1'b0}};
		pw_new_reg   <= 1'b0;
		overrun_reg  <= 1'b0;
		fifo_err_reg <= 1'b0;
	end else begin
		// set wins over a same-cycle clear
		if (clr_err_pulse) begin
			overrun_reg  <= 1'b0;
			fifo_err_reg <= 1'b0;
		end
		if (push && fifo_full)
			fifo_err_reg <= 1'b1;
		if (disarm_pulse) begin
			state_reg <= ST_IDLE;
		end else if (arm_pulse) begin
			count_reg  <= init_reg;
			pw_new_reg <= 1'b0;
			// edge counting runs from arm; pulse width waits for gate entry
			if (is_edge)
				state_reg <= ST_MEAS;
			else
				state_reg <= ST_WAIT;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					state_reg <= ST_IDLE;
				end
				ST_WAIT: begin
					// waits for a fresh leading edge, partial pulse dropped
					if (gate_lead) begin
						state_reg <= ST_MEAS;
						count_reg <= init_reg;
					end
				end
				ST_MEAS: begin
					if (is_edge) begin
						// sampling never touches the count
						if (src_edge && !paused) begin
							if (count_down)
								count_reg <= count_reg - 1'b1;
							else
								count_reg <= count_reg + 1'b1;
						end
					end else if (gate_trail) begin
						last_pw_reg <= count_reg;
						pw_new_reg  <= 1'b1;
						if (mode == `CEP_MODE_PW_ONE)
							state_reg <= ST_DONE;
						else
							state_reg <= ST_WAIT;
					end else if (gate_act && src_edge) begin
						count_reg <= count_reg + 1'b1;
					end
				end
				ST_DONE: begin
					state_reg <= ST_DONE;
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
			if (is_smp_pw && state_reg != ST_IDLE && smp_edge) begin
				if (!pw_new_reg)
					overrun_reg <= 1'b1;
				pw_new_reg <= (state_reg == ST_MEAS) & gate_trail;
			end
		end
	end
end

// ----------------------------------------
// result fifo, drained by dma
// ----------------------------------------
reg  [CW-1:0]    fifo_mem [0:FIFO_DEPTH-1];
reg  [FIFO_AW-1:0] wr_ptr_reg;
reg  [FIFO_AW-1:0] rd_ptr_reg;
reg  [FIFO_AW:0]   level_reg;
wire fifo_empty = (level_reg == {(FIFO_AW+1){1'b0}});
assign fifo_full = (level_reg == FIFO_DEPTH[FIFO_AW:0]);
wire do_wr = push & ~fifo_full;
wire do_rd = dma_valid & dma_ready;

always @(posedge aclk) begin
	if (do_wr)
		fifo_mem[wr_ptr_reg] <= push_data;
end

always @(posedge aclk) begin
	if (!aresetn) begin
		wr_ptr_reg <= {FIFO_AW{1'b0}};
		rd_ptr_reg <= {FIFO_AW{1'b0}};
		level_reg  <= {(FIFO_AW+1){1'b0}};
		dma_valid  <= 1'b0;
		dma_data   <= {CW{1'b0}};
	end else begin
		if (do_wr)
			wr_ptr_reg <= wr_ptr_reg + 1'b1;
		// output stage is a one-word skid holding the fifo head
		if ((!dma_valid || do_rd) && !fifo_empty) begin
			dma_data   <= fifo_mem[rd_ptr_reg];
			dma_valid  <= 1'b1;
			rd_ptr_reg <= rd_ptr_reg + 1'b1;
		end else if (do_rd) begin
			dma_valid <= 1'b0;
		end
		if (do_wr && !((!dma_valid || do_rd) && !fifo_empty))
			level_reg <= level_reg + 1'b1;
		else if (!do_wr && ((!dma_valid || do_rd) && !fifo_empty))
			level_reg <= level_reg - 1'b1;
	end
end

// ----------------------------------------
// axi4-lite slave
// ----------------------------------------
reg  [7:0] aw_addr_reg;
reg        aw_have_reg;
reg [31:0] w_data_reg;
reg [3:0]  w_strb_reg;
reg        w_have_reg;
wire       wr_go = aw_have_reg & w_have_reg & ~s_axi_bvalid;
reg [31:0] rd_word;
wire [31:0] status_word = {26'h0, fifo_full, fifo_empty, (state_reg == ST_DONE),
	fifo_err_reg, overrun_reg, (state_reg != ST_IDLE)};

always @* begin
	case (s_axi_araddr)
		`CEP_OFS_CFG:    rd_word = cfg_reg;
		`CEP_OFS_INIT:   rd_word = init_reg;
		`CEP_OFS_COUNT:  rd_word = count_reg;
		`CEP_OFS_STATUS: rd_word = status_word;
		`CEP_OFS_FIFO:   rd_word = last_pw_reg;
		`CEP_OFS_LEVEL:  rd_word = {{(31-FIFO_AW){1'b0}}, level_reg};
		default:         rd_word = 32'h0000_0000;
	endcase
end

wire rd_known = (s_axi_araddr == `CEP_OFS_CTRL) | (s_axi_araddr == `CEP_OFS_CFG)
	| (s_axi_araddr == `CEP_OFS_INIT) | (s_axi_araddr == `CEP_OFS_COUNT)
	| (s_axi_araddr == `CEP_OFS_STATUS) | (s_axi_araddr == `CEP_OFS_FIFO)
	| (s_axi_araddr == `CEP_OFS_LEVEL);

always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_awready <= 1'b0;
		s_axi_wready  <= 1'b0;
		s_axi_bvalid  <= 1'b0;
		s_axi_bresp   <= `CEP_AXI_OKAY;
		s_axi_arready <= 1'b0;
		s_axi_rvalid  <= 1'b0;
		s_axi_rresp   <= `CEP_AXI_OKAY;
		s_axi_rdata   <= 32'h0000_0000;
		aw_addr_reg   <= 8'h00;
		aw_have_reg   <= 1'b0;
		w_data_reg    <= 32'h0000_0000;
		w_strb_reg    <= 4'h0;
		w_have_reg    <= 1'b0;
		cfg_reg       <= `CEP_CFG_RESET;
		init_reg      <= {CW{1'b0}};
		sel_reg       <= 6'h00;
		arm_pulse     <= 1'b0;
		disarm_pulse  <= 1'b0;
		clr_err_pulse <= 1'b0;
		armed_out     <= 1'b0;
		error_out     <= 1'b0;
	end else begin
		arm_pulse     <= 1'b0;
		disarm_pulse  <= 1'b0;
		clr_err_pulse <= 1'b0;
		s_axi_awready <= ~aw_have_reg & ~s_axi_awready & s_axi_awvalid;
		s_axi_wready  <= ~w_have_reg & ~s_axi_wready & s_axi_wvalid;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_addr_reg <= s_axi_awaddr;
			aw_have_reg <= 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_data_reg <= s_axi_wdata;
			w_strb_reg <= s_axi_wstrb;
			w_have_reg <= 1'b1;
		end
		if (wr_go) begin
			aw_have_reg  <= 1'b0;
			w_have_reg   <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= `CEP_AXI_OKAY;
			case (aw_addr_reg)
				`CEP_OFS_CTRL: begin
					if (w_strb_reg[0]) begin
						arm_pulse     <= w_data_reg[`CEP_CTRL_ARM];
						disarm_pulse  <= w_data_reg[`CEP_CTRL_DISARM];
						clr_err_pulse <= w_data_reg[`CEP_CTRL_CLR_ERR];
					end
				end
				`CEP_OFS_CFG: begin
					if (w_strb_reg[0])
						cfg_reg[7:0] <= w_data_reg[7:0];
					if (w_strb_reg[1])
						cfg_reg[15:8] <= w_data_reg[15:8];
					if (w_strb_reg[2]) begin
						cfg_reg[23:16] <= w_data_reg[23:16];
						sel_reg        <= w_data_reg[`CEP_CFG_SEL_HI:`CEP_CFG_SEL_LO];
					end
				end
				`CEP_OFS_INIT: begin
					if (w_strb_reg[0])
						init_reg[7:0] <= w_data_reg[7:0];
					if (w_strb_reg[1])
						init_reg[15:8] <= w_data_reg[15:8];
					if (w_strb_reg[2])
						init_reg[23:16] <= w_data_reg[23:16];
					if (w_strb_reg[3])
						init_reg[31:24] <= w_data_reg[31:24];
				end
				`CEP_OFS_COUNT, `CEP_OFS_STATUS, `CEP_OFS_FIFO, `CEP_OFS_LEVEL: begin
					s_axi_bresp <= `CEP_AXI_OKAY;
				end
				default: begin
					s_axi_bresp <= `CEP_AXI_SLVERR;
				end
			endcase
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
		s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
		if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_known ? `CEP_AXI_OKAY : `CEP_AXI_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
		armed_out <= (state_reg != ST_IDLE) & (state_reg != ST_DONE);
		error_out <= overrun_reg | fifo_err_reg;
	end
end

endmodule

// >>> cep_counter_props.sv
// Purpose: port checks for the counter input engine
// Assumes: one clock domain, reset synchronous active low
// Notes: bound from the bench top
`timescale 1ns/1ns
`include "cep_defines.vh"
module cep_counter_props #(
	parameter CW = 32
) (
	// clock and reset
	input wire          aclk,
	input wire          aresetn,
	// register bus
	input wire          s_axi_wvalid,
	input wire          s_axi_wready,
	input wire [1:0]    s_axi_bresp,
	input wire          s_axi_bvalid,
	input wire          s_axi_bready,
	input wire [7:0]    s_axi_araddr,
	input wire          s_axi_arvalid,
	input wire          s_axi_arready,
	input wire [31:0]   s_axi_rdata,
	input wire [1:0]    s_axi_rresp,
	input wire          s_axi_rvalid,
	input wire          s_axi_rready,
	// stream and status
	input wire [CW-1:0] dma_data,
	input wire          dma_valid,
	input wire          dma_ready,
	input wire          armed_out,
	input wire          error_out
);
	// ----------------------------------------
	// helper: recent write data takes
	// ----------------------------------------
	logic [3:0] wr_hist;
	always @(posedge aclk) begin
		if (!aresetn)
			wr_hist <= 4'h0;
		else
			wr_hist <= {wr_hist[2:0], s_axi_wvalid & s_axi_wready};
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
	AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
		else $error("read answer late");
	AST_B_LAT: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write answer late");
	AST_AR_PULSE: assert property (s_axi_arready |=> !s_axi_arready)
		else $error("arready longer than one cycle");
	AST_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h18
		|-> ##[1:2] (s_axi_rvalid && s_axi_rresp == `CEP_AXI_SLVERR && s_axi_rdata == 32'h0))
		else $error("unmapped read not refused");
	AST_DMA_HOLD: assert property (dma_valid && !dma_ready |=> dma_valid && $stable(dma_data))
		else $error("stream result changed before taken");
	AST_ERR_CLR: assert property ($fell(error_out) |-> wr_hist != 4'h0)
		else $error("error flag cleared without a write");
	AST_ARM_SRC: assert property ($rose(armed_out) |-> wr_hist != 4'h0)
		else $error("armed without a write");
	// ----------------------------------------
	// covers
	// ----------------------------------------
	cover property (dma_valid && dma_ready);
	cover property ($rose(error_out));
	cover property ($rose(armed_out));
	cover property (s_axi_rvalid && s_axi_rresp == `CEP_AXI_SLVERR);
endmodule

// >>> cep_far_side.sv
// Purpose: routed source, gate, direction and sample lines
// Assumes: every change is held long enough for the input synchronisers
// Notes: lines are driven after rising edges only
`timescale 1ns/1ns
module cep_far_side #(
	parameter SEL_N = 43
) (
	// clock
	input wire               aclk,
	// lines toward the counter
	output logic             ctr_source,
	output logic             ctr_gate,
	output logic             ctr_aux_dir,
	output logic [SEL_N-1:0] sample_lines
);
	// two-flop sync plus edge detect needs several cycles per level
	localparam integer HOLD = 6;
	initial begin
		ctr_source = 1'h0;
		ctr_gate = 1'h0;
		ctr_aux_dir = 1'h0;
		sample_lines = '0;
	end
	// idx -1 source, -2 gate, -3 direction, else a sample line
	task drive(input integer idx, input logic v);
		@(posedge aclk);
		case (idx)
			-1: ctr_source <= v;
			-2: ctr_gate <= v;
			-3: ctr_aux_dir <= v;
			default: sample_lines[idx] <= v;
		endcase
		repeat (HOLD) @(posedge aclk);
	endtask
	task pulses(input integer n);
		repeat (n) begin
			drive(-1, 1'h1);
			drive(-1, 1'h0);
		end
	endtask
endmodule

// >>> cep_tb.sv
// Purpose: self-checking bench for the counter input engine
// Assumes: register map and fields of the shared defines
// Notes: the far side model drives all routed lines
`timescale 1ns/1ns
`include "cep_defines.vh"
module testbench;
	localparam integer SEL_N = `CEP_SEL_COUNT;
	localparam integer L_SRC = -1;
	localparam integer L_GATE = -2;
	localparam integer L_AUX = -3;
	logic             aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic             s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic             s_axi_rvalid, s_axi_rready, dma_valid, dma_ready, armed_out, error_out;
	logic             ctr_source, ctr_gate, ctr_aux_dir;
	logic [7:0]       s_axi_awaddr, s_axi_araddr;
	logic [31:0]      s_axi_wdata, s_axi_rdata, dma_data, rd_val;
	logic [3:0]       s_axi_wstrb;
	logic [1:0]       s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
	logic [SEL_N-1:0] sample_lines;
	integer           errors, checks_done, i, sl;

	cep_counter dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .ctr_source(ctr_source), .ctr_gate(ctr_gate),
		.ctr_aux_dir(ctr_aux_dir), .sample_lines(sample_lines), .dma_data(dma_data),
		.dma_valid(dma_valid), .dma_ready(dma_ready), .armed_out(armed_out), .error_out(error_out));
	cep_far_side #(.SEL_N(SEL_N)) far (.aclk(aclk), .ctr_source(ctr_source),
		.ctr_gate(ctr_gate), .ctr_aux_dir(ctr_aux_dir), .sample_lines(sample_lines));

	initial begin
		aclk = 1'h0;
		forever #5 aclk = ~aclk;
	end
	// ----------------------------------------
	// bus and compare tasks
	// ----------------------------------------
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done = checks_done + 1;
		if (got !== exp) begin
			errors = errors + 1;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		// response is left waiting one cycle so its hold is exercised
		s_axi_bready <= 1'h1;
		@(posedge aclk);
		wr_resp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'h1;
		@(posedge aclk);
		rd_val = s_axi_rdata;
		rd_resp = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task chk_rd(input string what, input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(what, exp, rd_val);
	endtask
	task pop(input logic [31:0] exp);
		@(posedge aclk);
		dma_ready <= 1'h1;
		do @(posedge aclk); while (!dma_valid);
		dma_ready <= 1'h0;
		chk("dma_data", exp, dma_data);
	endtask
	function automatic logic [31:0] cfg(input int md, fl, pe, ph, dr, sf, pl, sel);
		cfg = 32'(md + (fl << `CEP_CFG_SRC_FALL) + (pe << `CEP_CFG_PAUSE_EN)
			+ (ph << `CEP_CFG_PAUSE_HI) + (dr << `CEP_CFG_DIR_LO) + (sf << `CEP_CFG_SMP_FALL)
			+ (pl << `CEP_CFG_PW_LOW) + (sel << `CEP_CFG_SEL_LO));
	endfunction
	task arm(input logic [31:0] init, input logic [31:0] c);
		wr(`CEP_OFS_INIT, init);
		wr(`CEP_OFS_CFG, c);
		wr(`CEP_OFS_CTRL, 32'h1);
	endtask
	task tdone(input string name);
		$display("test %s ended", name);
	endtask
	task give_verdict;
		$display("comparisons %0d, mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#200000;
		chk("watchdog", 32'h0, 32'h1);
		give_verdict;
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		errors = 0;
		checks_done = 0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		s_axi_awaddr = 8'h0;
		s_axi_araddr = 8'h0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		dma_ready = 1'h0;
		aresetn = 1'h0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		chk_rd("cfg", `CEP_OFS_CFG, `CEP_CFG_RESET);
		chk_rd("count", `CEP_OFS_COUNT, 32'h0);
		chk_rd("status", `CEP_OFS_STATUS, 32'h10);
		chk_rd("unmapped", 8'h1C, 32'h0);
		chk("unmapped rresp", 32'(`CEP_AXI_SLVERR), 32'(rd_resp));
		wr(8'h1C, 32'h1);
		chk("unmapped bresp", 32'(`CEP_AXI_SLVERR), 32'(wr_resp));
		wr(`CEP_OFS_INIT, 32'hFFFF_FFFF);
		chk_rd("init", `CEP_OFS_INIT, 32'hFFFF_FFFF);
		s_axi_wstrb <= 4'h3;
		wr(`CEP_OFS_INIT, 32'h0);
		s_axi_wstrb <= 4'hF;
		chk_rd("init bytes", `CEP_OFS_INIT, 32'hFFFF_0000);
		tdone("reset");
		arm(32'h5, cfg(0, 0, 0, 0, 0, 0, 0, 0));
		far.pulses(3);
		chk_rd("count", `CEP_OFS_COUNT, 32'h8);
		chk_rd("count reread", `CEP_OFS_COUNT, 32'h8);
		chk("armed", 32'h1, 32'(armed_out));
		arm(32'h1, cfg(0, 0, 0, 0, 1, 0, 0, 0));
		far.pulses(3);
		chk_rd("down count", `CEP_OFS_COUNT, 32'hFFFF_FFFE);
		arm(32'hA, cfg(0, 0, 0, 0, 2, 0, 0, 0));
		far.drive(L_AUX, 1'h1);
		far.pulses(2);
		far.drive(L_AUX, 1'h0);
		far.pulses(1);
		chk_rd("aux count", `CEP_OFS_COUNT, 32'hB);
		arm(32'h0, cfg(0, 1, 0, 0, 0, 0, 0, 0));
		far.drive(L_SRC, 1'h1);
		chk_rd("rise ignored", `CEP_OFS_COUNT, 32'h0);
		far.drive(L_SRC, 1'h0);
		chk_rd("fall counted", `CEP_OFS_COUNT, 32'h1);
		wr(`CEP_OFS_CTRL, 32'h2);
		far.pulses(1);
		chk_rd("disarmed count", `CEP_OFS_COUNT, 32'h1);
		chk("disarmed", 32'h0, 32'(armed_out));
		tdone("edge count");
		for (i = 0; i < 2; i++) begin
			far.drive(L_GATE, i[0]);
			arm(32'h0, cfg(0, 0, 1, i, 0, 0, 0, 0));
			far.pulses(2);
			chk_rd("paused", `CEP_OFS_COUNT, 32'h0);
			far.drive(L_GATE, ~i[0]);
			far.pulses(2);
			chk_rd("unpaused", `CEP_OFS_COUNT, 32'h2);
		end
		tdone("pause");
		for (i = 0; i < 2; i++) begin
			sl = i ? 42 : 8;
			arm(32'h0, cfg(1, 0, 0, 0, 0, i, 0, sl));
			far.pulses(2);
			far.drive(sl, 1'h1);
			far.pulses(1);
			far.drive(sl, 1'h0);
			pop(i ? 32'h3 : 32'h2);
			far.pulses(2);
			far.drive(sl, 1'h1);
			far.drive(sl, 1'h0);
			pop(32'h5);
		end
		tdone("buffered edge");
		far.drive(L_GATE, 1'h1);
		arm(32'h0, cfg(2, 0, 0, 0, 0, 0, 0, 0));
		for (i = 2; i < 7; i += 2) begin
			far.drive(L_GATE, 1'h1);
			far.pulses(i);
			far.drive(L_GATE, 1'h0);
		end
		pop(32'h4);
		chk_rd("last width", `CEP_OFS_FIFO, 32'h4);
		rd(`CEP_OFS_STATUS);
		chk("done bit", 32'h1, 32'(rd_val[`CEP_ST_DONE]));
		chk("no second result", 32'h0, 32'(dma_valid));
		chk("done disarms", 32'h0, 32'(armed_out));
		far.drive(L_GATE, 1'h1);
		arm(32'h0, cfg(3, 1, 0, 0, 0, 0, 1, 0));
		for (i = 2; i < 4; i++) begin
			far.drive(L_GATE, 1'h0);
			far.pulses(i);
			far.drive(L_GATE, 1'h1);
		end
		pop(32'h2);
		pop(32'h3);
		tdone("pulse width");
		for (i = 4; i < 6; i++) begin
			far.drive(L_GATE, 1'h0);
			arm(32'h0, cfg(i, 0, 0, 0, 0, 0, 0, 8));
			far.drive(L_GATE, 1'h1);
			far.pulses(3);
			far.drive(L_GATE, 1'h0);
			far.drive(8, 1'h1);
			far.drive(8, 1'h0);
			pop(32'h3);
			far.drive(8, 1'h1);
			far.drive(8, 1'h0);
			chk("overrun", 32'h1, 32'(error_out));
			rd(`CEP_OFS_STATUS);
			chk("overrun bit", 32'h1, 32'(rd_val[`CEP_ST_OVERRUN]));
			wr(`CEP_OFS_CTRL, 32'h4);
			repeat (2) @(posedge aclk);
			chk("error cleared", 32'h0, 32'(error_out));
		end
		tdone("sampled pulse width");
		arm(32'h0, cfg(1, 0, 0, 0, 0, 0, 0, 8));
		repeat (18) begin
			far.drive(8, 1'h1);
			far.drive(8, 1'h0);
		end
		chk("fifo error", 32'h1, 32'(error_out));
		rd(`CEP_OFS_STATUS);
		chk("full bit", 32'h1, 32'(rd_val[`CEP_ST_FULL]));
		chk_rd("fifo level", `CEP_OFS_LEVEL, 32'h10);
		@(posedge aclk);
		dma_ready <= 1'h1;
		repeat (40) @(posedge aclk);
		dma_ready <= 1'h0;
		chk("drained", 32'h0, 32'(dma_valid));
		tdone("fifo full");
		give_verdict;
	end
endmodule

bind cep_counter cep_counter_props #(.CW(CW)) u_props (.aclk(aclk), .aresetn(aresetn),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.dma_data(dma_data), .dma_valid(dma_valid), .dma_ready(dma_ready),
	.armed_out(armed_out), .error_out(error_out));
